// ==== fbpe_top.sv ====
`timescale 1ns/1ps
module fbpe_top #(
	parameter int PAGES = 32,
	parameter logic [fbpe_pkg::WCOUNT_W-1:0] WRITE_THRESHOLD = 16'h2710
) (
	// Clock and reset.
	input wire logic MCLK,
	input wire logic RST_B,
	// Erase request from fabric logic.
	input wire logic PAGE_ERASE_REQUEST,
	input wire logic [fbpe_pkg::PAGE_ADDR_W-1:0] PAGE_ADDR,
	input wire logic OVERWRITE_PROTECT_INPUT,
	input wire logic PAGE_LOSS_GUARD_INPUT,
	// Page buffer state.
	input wire logic BUF_VALID,
	input wire logic [fbpe_pkg::PAGE_ADDR_W-1:0] BUF_PAGE,
	// Per-page markers from the array.
	input wire logic [PAGES-1:0] PAGE_PROTECTED,
	input wire logic [PAGES-1:0] PAGE_ECC_FAIL,
	// Data readback.
	input wire logic [fbpe_pkg::PAGE_ADDR_W-1:0] RD_PAGE,
	input wire logic [fbpe_pkg::WORD_IDX_W-1:0] RD_WORD,
	output logic [fbpe_pkg::PAGE_DATA_W-1:0] RD_DATA,
	// Answer.
	output logic BUSY,
	output logic DONE,
	output logic [1:0] STATUS
);
	typedef enum logic [2:0] {
		FBPE_IDLE = 3'b001,
		FBPE_WIPE = 3'b010,
		FBPE_END = 3'b100
	} fbpe_state_t;

	localparam int NW = fbpe_pkg::WORDS_PER_PAGE;

	fbpe_state_t state_r;
	fbpe_pkg::fbpe_req_t req_r;
	fbpe_pkg::fbpe_rsp_t rsp_r;
	logic req_q1_r, req_q2_r, req_q3_r;
	logic [fbpe_pkg::PAGE_DATA_W-1:0] mem_r [PAGES*NW];
	logic [fbpe_pkg::WCOUNT_W-1:0] wcount_r [PAGES];
	logic [fbpe_pkg::PAGE_DATA_W-1:0] rd_r;
	logic start, wipe_wr, wipe_last, refuse, ow_block, pl_block, at_end;
	logic [1:0] pre_status;
	logic [fbpe_pkg::WORD_IDX_W-1:0] wipe_idx;

	function automatic int word_at(input logic [fbpe_pkg::PAGE_ADDR_W-1:0] p,
			input logic [fbpe_pkg::WORD_IDX_W-1:0] w);
		return int'(p) * NW + int'(w);
	endfunction

	// Same page test for every counter in the generate loop below.
	function automatic logic page_is(
			input logic [fbpe_pkg::PAGE_ADDR_W-1:0] p, input int g);
		return int'(p) == g;
	endfunction

	// Refusal outranks the error codes, because a refused page is untouched.
	function automatic logic [1:0] erase_status(input logic refused,
			input logic ecc_bad, input logic worn);
		if (refused) begin
			return fbpe_pkg::ST_PROTECT;
		end else if (ecc_bad) begin
			return fbpe_pkg::ST_ECC;
		end else if (worn) begin
			return fbpe_pkg::ST_WEAR;
		end
		return fbpe_pkg::ST_OK;
	endfunction

	// Only a fresh request edge in idle starts an erase.
	assign start = (state_r == FBPE_IDLE) && req_q2_r && !req_q3_r;
	assign at_end = (state_r == FBPE_END);

	// Protection checks mirror the page program path.
	assign ow_block = OVERWRITE_PROTECT_INPUT
		&& PAGE_PROTECTED[PAGE_ADDR];
	// The guard only bites while the buffer really holds a page.
	assign pl_block = PAGE_LOSS_GUARD_INPUT && BUF_VALID
		&& BUF_PAGE != PAGE_ADDR;
	assign refuse = ow_block || pl_block;

	always_comb begin
		pre_status = erase_status(refuse, PAGE_ECC_FAIL[PAGE_ADDR],
			wcount_r[PAGE_ADDR] > WRITE_THRESHOLD);
	end

	fbpe_wipe #(.WORDS(NW)) u_wipe (
		.clk(MCLK),
		.rst_b(RST_B),
		.start(start && !refuse),
		.idx(wipe_idx),
		.wr(wipe_wr),
		.last(wipe_last)
	);

	// The request pin comes from fabric logic on another timing path.
	// Two stages settle it; the third keeps the old level for the edge test.
	always_ff @(posedge MCLK or negedge RST_B) begin
		if (!RST_B) begin
			req_q1_r <= 1'b0;
			req_q2_r <= 1'b0;
			req_q3_r <= 1'b0;
		end else begin
			req_q1_r <= PAGE_ERASE_REQUEST;
			req_q2_r <= req_q1_r;
			req_q3_r <= req_q2_r;
		end
	end

	// A refused erase goes straight to the end state and never starts the
	// wipe, so the page and its wear count stay as they were.
	always_ff @(posedge MCLK or negedge RST_B) begin
		if (!RST_B) begin
			state_r <= FBPE_IDLE;
		end else begin
			case (state_r)
				FBPE_IDLE: begin
					if (start) begin
						state_r <= refuse ? FBPE_END : FBPE_WIPE;
					end
				end
				FBPE_WIPE: begin
					if (wipe_last) begin
						state_r <= FBPE_END;
					end
				end
				FBPE_END: begin
					state_r <= FBPE_IDLE;
				end
				default: begin
					state_r <= FBPE_IDLE;
				end
			endcase
		end
	end

	// The page and the protect levels are held for the whole erase.
	always_ff @(posedge MCLK or negedge RST_B) begin
		if (!RST_B) begin
			req_r <= '0;
		end else if (start) begin
			req_r <= '{PAGE_ADDR, OVERWRITE_PROTECT_INPUT,
				PAGE_LOSS_GUARD_INPUT};
		end
	end

	// Status is taken at the start and stands until the next start, so it
	// can still be read well after the one-cycle done pulse.
	always_ff @(posedge MCLK or negedge RST_B) begin
		if (!RST_B) begin
			rsp_r <= '0;
		end else begin
			rsp_r.done <= at_end;
			if (start) begin
				rsp_r.busy <= 1'b1;
				rsp_r.status <= pre_status;
			end else if (at_end) begin
				rsp_r.busy <= 1'b0;
			end
		end
	end

	// Array contents and wear counters; no reset on the data itself.
	always_ff @(posedge MCLK) begin
		if (wipe_wr) begin
			mem_r[word_at(req_r.page, wipe_idx)] <= fbpe_pkg::ERASED_WORD;
		end
	end

	// One saturating wear counter per page; a full counter stays full, so a
	// worn page cannot look fresh again until reset loads WCOUNT_RST.
	generate
		for (genvar g = 0; g < PAGES; g++) begin : g_wear
			always_ff @(posedge MCLK or negedge RST_B) begin
				if (!RST_B) begin
					wcount_r[g] <= fbpe_pkg::WCOUNT_RST;
				end else if (wipe_last && page_is(req_r.page, g)
						&& wcount_r[g] != '1) begin
					wcount_r[g] <= wcount_r[g] + fbpe_pkg::WCOUNT_W'(1);
				end
			end
		end
	endgenerate

	// Readback has one cycle of latency, like the array it stands for.

	always_ff @(posedge MCLK or negedge RST_B) begin
		if (!RST_B) begin
			rd_r <= '0;
		end else begin
			rd_r <= mem_r[word_at(RD_PAGE, RD_WORD)];
		end
	end

	assign RD_DATA = rd_r;
	assign BUSY = rsp_r.busy;
	assign DONE = rsp_r.done;
	assign STATUS = rsp_r.status;
endmodule

// ==== fbpe_pkg.sv ====
package fbpe_pkg;
	localparam int PAGE_ADDR_W = 5;
	localparam int PAGE_DATA_W = 32;
	localparam int WORDS_PER_PAGE = 8;
	localparam int WORD_IDX_W = 3;
	localparam int WCOUNT_W = 16;

	localparam logic [1:0] ST_OK = 2'h0;
	localparam logic [1:0] ST_PROTECT = 2'h1;
	localparam logic [1:0] ST_ECC = 2'h2;
	localparam logic [1:0] ST_WEAR = 2'h3;

	localparam logic [PAGE_DATA_W-1:0] ERASED_WORD = 32'h00000000;
	localparam logic [WCOUNT_W-1:0] WCOUNT_RST = 16'h0000;

	typedef struct packed {
		logic [PAGE_ADDR_W-1:0] page;
		logic overwrite_protect_input;
		logic page_loss_guard_input;
	} fbpe_req_t;

	typedef struct packed {
		logic busy;
		logic done;
		logic [1:0] status;
	} fbpe_rsp_t;
endpackage

// ==== fbpe_wipe.sv ====
`timescale 1ns/1ps
module fbpe_wipe #(
	parameter int WORDS = fbpe_pkg::WORDS_PER_PAGE
) (
	// Clock and reset.
	input wire logic clk,
	input wire logic rst_b,
	// Control.
	input wire logic start,
	output logic [fbpe_pkg::WORD_IDX_W-1:0] idx,
	output logic wr,
	output logic last
);
	logic [fbpe_pkg::WORD_IDX_W-1:0] idx_r;
	logic run_r;

	assign idx = idx_r;
	assign wr = run_r;
	assign last = run_r && (idx_r == fbpe_pkg::WORD_IDX_W'(WORDS - 1));

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			run_r <= 1'b0;
			idx_r <= '0;
		end else if (start) begin
			run_r <= 1'b1;
			idx_r <= '0;
		end else if (last) begin
			run_r <= 1'b0;
		end else if (run_r) begin
			idx_r <= idx_r + fbpe_pkg::WORD_IDX_W'(1);
		end
	end
endmodule

// ==== fbpe_monitor.sv ====
`timescale 1ns/1ps
module fbpe_monitor #(
	parameter int PAGES = 32
) (
	// Clock and reset.
	input wire logic MCLK,
	input wire logic RST_B,
	// Request.
	input wire logic PAGE_ERASE_REQUEST,
	input wire logic [4:0] PAGE_ADDR,
	input wire logic OVERWRITE_PROTECT_INPUT,
	input wire logic PAGE_LOSS_GUARD_INPUT,
	input wire logic BUF_VALID,
	input wire logic [4:0] BUF_PAGE,
	input wire logic [PAGES-1:0] PAGE_PROTECTED,
	// Answer.
	input wire logic BUSY,
	input wire logic DONE,
	input wire logic [1:0] STATUS
);
	default clocking @(posedge MCLK); endclocking
	default disable iff (!RST_B);
	property p_rq; $rose(BUSY) |-> $past(PAGE_ERASE_REQUEST); endproperty
	property p_ow; $rose(BUSY) && $past(OVERWRITE_PROTECT_INPUT &&
		PAGE_PROTECTED[PAGE_ADDR]) |-> STATUS == 2'h1; endproperty
	property p_pl; $rose(BUSY) && $past(PAGE_LOSS_GUARD_INPUT && BUF_VALID
		&& BUF_PAGE != PAGE_ADDR) |-> STATUS == 2'h1; endproperty
	property p_rf; $rose(BUSY) && STATUS == 2'h1 |-> ##[1:3] DONE; endproperty
	property p_er; $rose(BUSY) && STATUS != 2'h1 |->
		!DONE [*8] ##[1:3] DONE; endproperty
	property p_dn; DONE |=> !DONE; endproperty
	property p_hd; !$rose(BUSY) |-> $stable(STATUS); endproperty
	property p_fl; $fell(BUSY) |-> DONE; endproperty
	a_rq: assert property (p_rq) else $error("no request");
	a_ow: assert property (p_ow) else $error("protect");
	a_pl: assert property (p_pl) else $error("guard");
	a_rf: assert property (p_rf) else $error("refuse");
	a_er: assert property (p_er) else $error("erase time");
	a_dn: assert property (p_dn) else $error("done long");
	a_hd: assert property (p_hd) else $error("status");
	a_fl: assert property (p_fl) else $error("busy end");
	c_ok: cover property ($rose(BUSY) && STATUS == 2'h0);
	c_pr: cover property ($rose(BUSY) && STATUS == 2'h1);
	c_wr: cover property ($rose(BUSY) && STATUS == 2'h3);
	c_ec: cover property ($rose(BUSY) && STATUS == 2'h2);
endmodule
bind fbpe_top fbpe_monitor #(.PAGES(PAGES)) u_mon (.MCLK(MCLK),
	.RST_B(RST_B), .PAGE_ERASE_REQUEST(PAGE_ERASE_REQUEST),
	.PAGE_ADDR(PAGE_ADDR), .OVERWRITE_PROTECT_INPUT(OVERWRITE_PROTECT_INPUT),
	.PAGE_LOSS_GUARD_INPUT(PAGE_LOSS_GUARD_INPUT), .BUF_VALID(BUF_VALID),
	.BUF_PAGE(BUF_PAGE), .PAGE_PROTECTED(PAGE_PROTECTED), .BUSY(BUSY),
	.DONE(DONE), .STATUS(STATUS));

// ==== fbpe_fabric.sv ====
`timescale 1ns/1ps
module fbpe_fabric (
	// Clock and handshake.
	input wire logic clk,
	input wire logic go,
	input wire logic done,
	output logic req = 1'b0
);
	// The level is held until the answer, so no edge is lost.
	always @(posedge clk) begin
		if (done)
			req <= 1'b0;
		else if (go)
			req <= 1'b1;
	end
endmodule

// ==== fbpe_top_tb.sv ====
`timescale 1ns/1ps
module fbpe_top_tb;
	typedef struct packed {
		logic [4:0] pg;
		logic ow;
		logic pl;
		logic [1:0] st;
	} fbpe_row_t;
	// Threshold 0 makes the second erase of a page a worn one.
	fbpe_row_t rows [7] = '{9'h030, 9'h059, 9'h050, 9'h045, 9'h074,
		9'h092, 9'h033};
	logic clk = 1'b0, rst_b = 1'b0, go = 1'b0, req, ow = 1'b0, pl = 1'b0;
	logic bv = 1'b1;
	logic busy, done;
	logic [4:0] pg = 5'h00;
	logic [2:0] wd = 3'h0;
	logic [31:0] rd;
	logic [1:0] st;
	int n_errors = 0, n_tests = 0, cyc = 0;
	fbpe_top #(.PAGES(32), .WRITE_THRESHOLD(16'h0000)) uut (.MCLK(clk),
		.RST_B(rst_b), .PAGE_ERASE_REQUEST(req), .PAGE_ADDR(pg),
		.OVERWRITE_PROTECT_INPUT(ow), .PAGE_LOSS_GUARD_INPUT(pl),
		.BUF_VALID(bv), .BUF_PAGE(5'h07), .PAGE_PROTECTED(32'h00000020),
		.PAGE_ECC_FAIL(32'h00000200), .RD_PAGE(pg), .RD_WORD(wd),
		.RD_DATA(rd), .BUSY(busy), .DONE(done), .STATUS(st));
	fbpe_fabric u_fab (.clk(clk), .go(go), .done(done), .req(req));
	initial forever #5 clk = ~clk;
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			n_errors++;
			$display("ERROR t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic report_and_stop();
		$display("checks %0d errors %0d", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	always @(posedge clk) begin
		cyc = cyc + 1;
		if (cyc == 3000) begin
			n_errors++;
			$display("ERROR t=%0t timeout", $time);
			report_and_stop();
		end
	end
	task automatic run_erase(input fbpe_row_t r);
		logic seen;
		seen = 1'b0;
		@(posedge clk);
		pg <= r.pg;
		ow <= r.ow;
		pl <= r.pl;
		go <= 1'b1;
		@(posedge clk);
		go <= 1'b0;
		repeat (40) if (done !== 1'b1) begin
			@(negedge clk);
			seen = seen | busy;
		end
		chk({31'h0, seen}, 32'h1);
		chk({31'h0, done}, 32'h1);
		chk({30'h0, st}, {30'h0, r.st});
		for (int w = 0; w < 8 && r.st != 2'h1; w++) begin
			@(posedge clk);
			wd <= w[2:0];
			@(posedge clk);
			@(negedge clk);
			chk(rd, 32'h0);
		end
	endtask
	initial begin
		repeat (6) @(posedge clk);
		rst_b <= 1'b1;
		foreach (rows[i]) begin
			run_erase(rows[i]);
			$display("test %0d ended", i);
		end
		@(posedge clk);
		rst_b <= 1'b0;
		@(negedge clk);
		chk({28'h0, busy, done, st}, 32'h0);
		chk(rd, 32'h0);
		@(posedge clk);
		rst_b <= 1'b1;
		bv <= 1'b0;
		@(negedge clk);
		chk({28'h0, busy, done, st}, 32'h0);
		// No buffered page lifts the guard, and reset restarts the wear count.
		run_erase(9'h034);
		$display("reset test ended");
		report_and_stop();
	end
endmodule
